// >>> rtl/dlc_core.sv
// Display list coprocessor with APB register slave
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`include "dlc_regs.svh"
`default_nettype none

module dlc_core (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic odd_cycle_in,
    input wire logic mem_grant_in,
    input wire logic [15:0] mem_data_in,
    input wire logic [7:0] beam_v_in,
    input wire logic [7:0] beam_h_in,
    input wire logic vblank_start_in,
    input wire logic blit_done_in,
    output dlc_pkg::dlc_mem_req_t mem_req_out,
    output dlc_pkg::dlc_rga_t rga_out
);

    // ****************************************
    // Functions
    // ****************************************
    // Masked beam comparison: vertical top bit is never masked
    function automatic logic beam_reached(input logic [15:0] w1, input logic [15:0] w2,
                                          input logic [7:0] v, input logic [7:0] h,
                                          input logic done);
        logic [14:0] mask;
        logic [14:0] beam;
        logic [14:0] tgt;
        mask = {1'b1, w2[14:8], w2[7:1]};
        beam = {v, h[7:1]} & mask;
        tgt = {w1[15:8], w1[7:1]} & mask;
        beam_reached = (beam >= tgt) && (w2[`DLC_BLIT_IGNORE_BIT] || done);
    endfunction

    // Register bus address that must trigger a jump
    function automatic logic [1:0] jump_hit(input logic [7:0] a);
        jump_hit = {a == `DLC_RGA_JUMP_SECOND, a == `DLC_RGA_JUMP_FIRST};
    endfunction

    // ****************************************
    // Declarations
    // ****************************************
    dlc_pkg::dlc_state_t state_ff;
    logic [17:0] pc_ff;
    logic [17:0] loc1_ff;
    logic [17:0] loc2_ff;
    logic [15:0] control_ff;
    logic run_ff;
    logic skip_ff;
    logic [15:0] word1_ff;
    logic [15:0] word2_ff;
    logic [7:0] v_s1_ff;
    logic [7:0] v_ff;
    logic [7:0] h_s1_ff;
    logic [7:0] h_ff;
    logic [2:0] vb_s_ff;
    logic [1:0] bd_s_ff;
    logic apb_wr;
    logic apb_rd;
    logic [11:0] a;
    logic mv_wr;
    logic [7:0] mv_addr;
    logic mv_allowed;
    logic vb_edge;
    logic [1:0] apb_jump;
    logic [1:0] mv_jump;
    logic move_word2;

    // ****************************************
    // Input synchronisers
    // ****************************************
    // Beam, blank and blitter flag come from another block's pins
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            v_s1_ff <= 8'h00;
            v_ff <= 8'h00;
            h_s1_ff <= 8'h00;
            h_ff <= 8'h00;
            vb_s_ff <= 3'h0;
            bd_s_ff <= 2'h0;
        end else begin
            v_s1_ff <= beam_v_in;
            v_ff <= v_s1_ff;
            h_s1_ff <= beam_h_in;
            h_ff <= h_s1_ff;
            vb_s_ff <= {vb_s_ff[1:0], vblank_start_in};
            bd_s_ff <= {bd_s_ff[0], blit_done_in};
        end
    end
    assign vb_edge = vb_s_ff[1] & ~vb_s_ff[2];

    // ****************************************
    // APB decode
    // ****************************************
    // Zero wait state: pready is registered high for the access cycle after setup
    assign a = paddr_in;
    assign apb_wr = psel_in & penable_in & pwrite_in;
    assign apb_rd = psel_in & ~pwrite_in;
    assign apb_jump = {apb_wr && a == `DLC_OFF_JUMP_SECOND, apb_wr && a == `DLC_OFF_JUMP_FIRST};

    // MOVE write from the second-word fetch
    assign move_word2 = (state_ff == dlc_pkg::DLC_FETCH2) && mem_grant_in && !word1_ff[`DLC_TYPE_BIT];
    assign mv_addr = word1_ff[8:1];
    // Blitter range needs the danger bit
    assign mv_allowed = (mv_addr >= `DLC_RGA_BLIT_LIMIT) || (mv_addr < `DLC_RGA_BLIT_BASE)
                        || control_ff[`DLC_DANGER_BIT];
    assign mv_wr = move_word2 && !skip_ff && mv_allowed;
    assign mv_jump = mv_wr ? jump_hit(mv_addr) : 2'b00;

    // Read data mux
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prdata_out <= 32'h00000000;
            pslverr_out <= 1'b0;
            pready_out <= 1'b0;
        end else begin
            pready_out <= psel_in & ~penable_in;
            pslverr_out <= 1'b0;
            if (apb_rd & ~penable_in) begin
                unique case (a)
                    `DLC_OFF_CONTROL: prdata_out <= {16'h0000, control_ff};
                    `DLC_OFF_LOC1_HIGH: prdata_out <= {29'h00000000, loc1_ff[17:15]};
                    `DLC_OFF_LOC1_LOW: prdata_out <= {16'h0000, loc1_ff[14:0], 1'b0};
                    `DLC_OFF_LOC2_HIGH: prdata_out <= {29'h00000000, loc2_ff[17:15]};
                    `DLC_OFF_LOC2_LOW: prdata_out <= {16'h0000, loc2_ff[14:0], 1'b0};
                    `DLC_OFF_STATUS: prdata_out <= {11'h000, state_ff, pc_ff};
                    `DLC_OFF_RUN: prdata_out <= {31'h00000000, run_ff};
                    `DLC_OFF_JUMP_FIRST, `DLC_OFF_JUMP_SECOND: prdata_out <= 32'h00000000;
                    default: begin
                        prdata_out <= 32'h00000000;
                        pslverr_out <= 1'b1;
                    end
                endcase
            end else if (psel_in & ~penable_in) begin
                prdata_out <= 32'h00000000;
                pslverr_out <= !(a inside {`DLC_OFF_CONTROL, `DLC_OFF_JUMP_FIRST,
                    `DLC_OFF_JUMP_SECOND, `DLC_OFF_LOC1_HIGH, `DLC_OFF_LOC1_LOW,
                    `DLC_OFF_LOC2_HIGH, `DLC_OFF_LOC2_LOW, `DLC_OFF_RUN});
            end
        end
    end

    // ****************************************
    // Control and location registers
    // ****************************************
    // Processor writes and own MOVE writes share these registers
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            control_ff <= `DLC_CONTROL_RESET;
            loc1_ff <= `DLC_LOC_RESET;
            loc2_ff <= `DLC_LOC_RESET;
            run_ff <= 1'b0;
        end else if (apb_wr && pready_out) begin
            unique case (a)
                `DLC_OFF_CONTROL: control_ff <= {14'h0000, pwdata_in[`DLC_DANGER_BIT], 1'b0};
                `DLC_OFF_LOC1_HIGH: loc1_ff[17:15] <= pwdata_in[2:0];
                `DLC_OFF_LOC1_LOW: loc1_ff[14:0] <= pwdata_in[15:1];
                `DLC_OFF_LOC2_HIGH: loc2_ff[17:15] <= pwdata_in[2:0];
                `DLC_OFF_LOC2_LOW: loc2_ff[14:0] <= pwdata_in[15:1];
                `DLC_OFF_RUN: run_ff <= pwdata_in[`DLC_RUN_BIT];
                default: begin
                end
            endcase
        end else if (mv_wr) begin
            unique case (mv_addr)
                `DLC_RGA_CONTROL: control_ff <= {14'h0000, mem_data_in[`DLC_DANGER_BIT], 1'b0};
                `DLC_RGA_LOC1_HIGH: loc1_ff[17:15] <= mem_data_in[2:0];
                `DLC_RGA_LOC1_LOW: loc1_ff[14:0] <= mem_data_in[15:1];
                `DLC_RGA_LOC2_HIGH: loc2_ff[17:15] <= mem_data_in[2:0];
                `DLC_RGA_LOC2_LOW: loc2_ff[14:0] <= mem_data_in[15:1];
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    // Two word fetches per instruction on odd cycles only
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_ff <= dlc_pkg::DLC_IDLE;
            pc_ff <= `DLC_LOC_RESET;
            word1_ff <= 16'h0000;
            word2_ff <= 16'h0000;
            skip_ff <= 1'b0;
        end else if (apb_jump[0] && pready_out || mv_jump[0] || vb_edge) begin
            pc_ff <= loc1_ff;
            skip_ff <= 1'b0;
            state_ff <= run_ff ? dlc_pkg::DLC_REQ1 : dlc_pkg::DLC_IDLE;
        end else if (apb_jump[1] && pready_out || mv_jump[1]) begin
            pc_ff <= loc2_ff;
            skip_ff <= 1'b0;
            state_ff <= run_ff ? dlc_pkg::DLC_REQ1 : dlc_pkg::DLC_IDLE;
        end else if (!run_ff) begin
            state_ff <= dlc_pkg::DLC_IDLE;
        end else begin
            unique case (state_ff)
                dlc_pkg::DLC_IDLE: state_ff <= dlc_pkg::DLC_REQ1;
                dlc_pkg::DLC_REQ1: if (odd_cycle_in) state_ff <= dlc_pkg::DLC_FETCH1;
                dlc_pkg::DLC_FETCH1: if (mem_grant_in) begin
                    word1_ff <= mem_data_in;
                    pc_ff <= pc_ff + 18'h00001;
                    state_ff <= dlc_pkg::DLC_REQ2;
                end
                dlc_pkg::DLC_REQ2: if (odd_cycle_in) state_ff <= dlc_pkg::DLC_FETCH2;
                dlc_pkg::DLC_FETCH2: if (mem_grant_in) begin
                    word2_ff <= mem_data_in;
                    pc_ff <= pc_ff + 18'h00001;
                    if (!word1_ff[`DLC_TYPE_BIT]) begin
                        skip_ff <= 1'b0;
                        state_ff <= dlc_pkg::DLC_REQ1;
                    end else if (mem_data_in[`DLC_TYPE_BIT]) begin
                        skip_ff <= beam_reached(word1_ff, mem_data_in, v_ff, h_ff,
                                                bd_s_ff[1]);
                        state_ff <= dlc_pkg::DLC_REQ1;
                    end else begin
                        state_ff <= dlc_pkg::DLC_WAIT;
                    end
                end
                dlc_pkg::DLC_WAIT:
                    if (beam_reached(word1_ff, word2_ff, v_ff, h_ff, bd_s_ff[1]))
                        state_ff <= dlc_pkg::DLC_REQ1;
            endcase
        end
    end

    // ****************************************
    // Outputs toward arbiter and register bus
    // ****************************************
    // Request only in REQ1 and REQ2 on odd cycles; none while waiting
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mem_req_out <= '0;
            rga_out <= '0;
        end else begin
            mem_req_out.req <= run_ff && odd_cycle_in && (state_ff == dlc_pkg::DLC_REQ1 ||
                               state_ff == dlc_pkg::DLC_REQ2);
            mem_req_out.addr <= pc_ff;
            rga_out.strobe <= mv_wr;
            rga_out.addr <= move_word2 ? mv_addr : `DLC_RGA_FETCH_IDENT;
            rga_out.data <= mem_data_in;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    property p_danger_reset;
        @(posedge core_clk_in) $rose(rstn_in) |-> !control_ff[`DLC_DANGER_BIT];
    endproperty
    a_danger_reset: assert property (p_danger_reset) else $error("danger bit set after reset");

    property p_blit_refused;
        @(posedge core_clk_in) disable iff (!rstn_in)
        move_word2 && !control_ff[`DLC_DANGER_BIT] && mv_addr >= `DLC_RGA_BLIT_BASE &&
        mv_addr < `DLC_RGA_BLIT_LIMIT |=> !rga_out.strobe;
    endproperty
    a_blit_refused: assert property (p_blit_refused) else $error("blitter write leaked");

    property p_jump1;
        @(posedge core_clk_in) disable iff (!rstn_in)
        apb_wr && pready_out && a == `DLC_OFF_JUMP_FIRST |=> pc_ff == $past(loc1_ff);
    endproperty
    a_jump1: assert property (p_jump1) else $error("jump first failed");

    property p_move_jump;
        @(posedge core_clk_in) disable iff (!rstn_in)
        mv_wr && mv_addr == `DLC_RGA_JUMP_SECOND && !vb_edge && !apb_jump[0]
        |=> pc_ff == $past(loc2_ff);
    endproperty
    a_move_jump: assert property (p_move_jump) else $error("move jump failed");

    property p_vblank;
        @(posedge core_clk_in) disable iff (!rstn_in) vb_edge |=> pc_ff == $past(loc1_ff);
    endproperty
    a_vblank: assert property (p_vblank) else $error("vblank reload failed");

    property p_wait_noreq;
        @(posedge core_clk_in) disable iff (!rstn_in)
        state_ff == dlc_pkg::DLC_WAIT |=> !mem_req_out.req;
    endproperty
    a_wait_noreq: assert property (p_wait_noreq) else $error("request while waiting");

    property p_odd_only;
        @(posedge core_clk_in) disable iff (!rstn_in)
        $rose(mem_req_out.req) |-> $past(odd_cycle_in);
    endproperty
    a_odd_only: assert property (p_odd_only) else $error("request on even cycle");

    property p_ident;
        @(posedge core_clk_in) disable iff (!rstn_in)
        !move_word2 |=> rga_out.addr == `DLC_RGA_FETCH_IDENT;
    endproperty
    a_ident: assert property (p_ident) else $error("identify address missing");

    property p_move_data;
        @(posedge core_clk_in) disable iff (!rstn_in)
        mv_wr |=> rga_out.strobe && rga_out.data == $past(mem_data_in) &&
        rga_out.addr == $past(mv_addr);
    endproperty
    a_move_data: assert property (p_move_data) else $error("move data wrong");

    property p_loc_split;
        @(posedge core_clk_in) disable iff (!rstn_in)
        apb_wr && pready_out && a == `DLC_OFF_LOC1_LOW
        |=> loc1_ff[17:15] == $past(loc1_ff[17:15]);
    endproperty
    a_loc_split: assert property (p_loc_split) else $error("low write touched high part");

    property p_jump2;
        @(posedge core_clk_in) disable iff (!rstn_in)
        apb_wr && pready_out && a == `DLC_OFF_JUMP_SECOND && !vb_edge && !mv_jump[0]
        |=> pc_ff == $past(loc2_ff);
    endproperty
    a_jump2: assert property (p_jump2) else $error("jump second failed");

    property p_two_words;
        @(posedge core_clk_in) disable iff (!rstn_in)
        state_ff == dlc_pkg::DLC_FETCH1 && mem_grant_in && run_ff
        && apb_jump == 2'b00 && !vb_edge
        |=> state_ff == dlc_pkg::DLC_REQ2;
    endproperty
    a_two_words: assert property (p_two_words) else $error("second word not fetched");

    property p_skip_move;
        @(posedge core_clk_in) disable iff (!rstn_in)
        move_word2 && skip_ff |=> !rga_out.strobe;
    endproperty
    a_skip_move: assert property (p_skip_move) else $error("skipped move written");

    property p_blit_hold;
        @(posedge core_clk_in) disable iff (!rstn_in)
        state_ff == dlc_pkg::DLC_WAIT && run_ff && !word2_ff[`DLC_BLIT_IGNORE_BIT]
        && !bd_s_ff[1] && apb_jump == 2'b00 && !vb_edge
        |=> state_ff == dlc_pkg::DLC_WAIT;
    endproperty
    a_blit_hold: assert property (p_blit_hold) else $error("left wait before blit done");

    c_wait: cover property (@(posedge core_clk_in) state_ff == dlc_pkg::DLC_WAIT ##1
        state_ff == dlc_pkg::DLC_REQ1);
    c_skip: cover property (@(posedge core_clk_in) skip_ff && move_word2);
    c_move: cover property (@(posedge core_clk_in) rga_out.strobe);
    c_blit_wait: cover property (@(posedge core_clk_in) state_ff == dlc_pkg::DLC_WAIT &&
        !word2_ff[`DLC_BLIT_IGNORE_BIT] && !bd_s_ff[1]);
    c_vblank: cover property (@(posedge core_clk_in) vb_edge && state_ff == dlc_pkg::DLC_WAIT);

endmodule // dlc_core
`default_nettype wire

// >>> rtl/dlc_regs.svh
// Register offsets, bus addresses, field positions and reset values of the display list coprocessor
`ifndef DLC_REGS_SVH
`define DLC_REGS_SVH
// APB byte offsets
`define DLC_OFF_CONTROL 12'h000
`define DLC_OFF_JUMP_FIRST 12'h004
`define DLC_OFF_JUMP_SECOND 12'h008
`define DLC_OFF_LOC1_HIGH 12'h00C
`define DLC_OFF_LOC1_LOW 12'h010
`define DLC_OFF_LOC2_HIGH 12'h014
`define DLC_OFF_LOC2_LOW 12'h018
`define DLC_OFF_STATUS 12'h01C
`define DLC_OFF_RUN 12'h020
// Register bus addresses seen by MOVE (word address on the register bus)
`define DLC_RGA_CONTROL 8'h2E
`define DLC_RGA_JUMP_FIRST 8'h88
`define DLC_RGA_JUMP_SECOND 8'h8A
`define DLC_RGA_LOC1_HIGH 8'h80
`define DLC_RGA_LOC1_LOW 8'h82
`define DLC_RGA_LOC2_HIGH 8'h84
`define DLC_RGA_LOC2_LOW 8'h86
`define DLC_RGA_FETCH_IDENT 8'h8C
`define DLC_RGA_BLIT_LIMIT 8'h80
`define DLC_RGA_BLIT_BASE 8'h40
// Field positions
`define DLC_DANGER_BIT 1
`define DLC_BLIT_IGNORE_BIT 15
`define DLC_TYPE_BIT 0
`define DLC_RUN_BIT 0
// Reset values
`define DLC_CONTROL_RESET 16'h0000
`define DLC_LOC_RESET 18'h00000
`endif

// >>> rtl/dlc_pkg.sv
// Types shared by the display list coprocessor
package dlc_pkg;
    typedef enum logic [2:0] {
        DLC_IDLE, DLC_REQ1, DLC_FETCH1, DLC_REQ2, DLC_FETCH2, DLC_WAIT
    } dlc_state_t;
    // Bus request toward the DMA arbiter
    typedef struct packed {
        logic req;
        logic [17:0] addr;
    } dlc_mem_req_t;
    // Write placed on the register address bus
    typedef struct packed {
        logic strobe;
        logic [7:0] addr;
        logic [15:0] data;
    } dlc_rga_t;
endpackage

// >>> sim/dlc_mem_model.sv
// Bus arbiter and shared RAM model facing the coprocessor fetch port
`timescale 1ns/10ps
`default_nettype none
module dlc_mem_model (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic slow_in,
    input wire dlc_pkg::dlc_mem_req_t mem_req_in,
    output logic odd_cycle_out,
    output logic mem_grant_out,
    output logic [15:0] mem_data_out
);
    // ****************************************
    // RAM and arbiter
    // ****************************************
    logic [15:0] ram [bit [17:0]];
    logic busy_ff;
    logic [17:0] addr_ff;
    logic [2:0] wait_ff;

    // Program loader for the bench
    task automatic load(input logic [17:0] a, input logic [15:0] d);
        ram[a] = d;
    endtask

    // Slot parity, odd slots are the ones the coprocessor may use
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            odd_cycle_out <= 1'b0;
        end else begin
            odd_cycle_out <= ~odd_cycle_out;
        end
    end

    // One grant per requested word, data line churns outside a grant
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            busy_ff <= 1'b0;
            addr_ff <= 18'h00000;
            wait_ff <= 3'h0;
            mem_grant_out <= 1'b0;
            mem_data_out <= 16'h0000;
        end else begin
            mem_grant_out <= 1'b0;
            mem_data_out <= ~mem_data_out;
            if (busy_ff) begin
                if (wait_ff == 3'h0) begin
                    mem_grant_out <= 1'b1;
                    mem_data_out <= ram.exists(addr_ff) ? ram[addr_ff] : ~addr_ff[15:0];
                    busy_ff <= 1'b0;
                    wait_ff <= 3'h1;
                end else begin
                    wait_ff <= wait_ff - 3'h1;
                end
            end else if (wait_ff != 3'h0) begin
                wait_ff <= wait_ff - 3'h1;
            end else if (mem_req_in.req === 1'b1) begin
                busy_ff <= 1'b1;
                addr_ff <= mem_req_in.addr;
                wait_ff <= slow_in ? 3'h4 : 3'h0;
            end
        end
    end
endmodule // dlc_mem_model
`default_nettype wire

// >>> sim/tb_display_list_coprocessor.sv
// Self-checking bench for the display list coprocessor
`timescale 1ns/10ps
`default_nettype none
`include "dlc_regs.svh"
module tb_display_list_coprocessor;
    // ****************************************
    // Signals and programs
    // ****************************************
    logic clk, rstn, psel, pen, pwr, odd, grant, vbl, slow, pready, perr, er, bdone;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] mdata;
    logic [7:0] beam_v, beam_h;
    logic [17:0] last_adr;
    dlc_pkg::dlc_mem_req_t mreq;
    dlc_pkg::dlc_rga_t register_address_bus;
    int mismatches, checks_done, reqs, idents;
    logic [23:0] q_rga [$];
    logic [17:0] q_adr [$];
    localparam logic [17:0] LOC_A = 18'h08100;
    localparam logic [17:0] LOC_B = 18'h00200;
    localparam logic [15:0] PROG_A [18] = '{16'h0140, 16'hBEEF, 16'h0080, 16'h1111,
        16'h2001, 16'hFF00, 16'h0144, 16'h0001, 16'h0001, 16'h7F01, 16'h0148, 16'h2222,
        16'h0001, 16'hFF01, 16'h014C, 16'h3333, 16'h0114, 16'h0000};
    localparam logic [15:0] PROG_B [12] = '{16'h8001, 16'h8000, 16'h005C, 16'h0002,
        16'h0080, 16'h4444, 16'hFFFF, 16'hFFFE, 16'h0001, 16'h0000, 16'hFFFF, 16'hFFFE};

    dlc_core dut (.core_clk_in(clk), .rstn_in(rstn), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(perr), .odd_cycle_in(odd), .mem_grant_in(grant),
        .mem_data_in(mdata), .beam_v_in(beam_v), .beam_h_in(beam_h), .vblank_start_in(vbl),
        .blit_done_in(bdone), .mem_req_out(mreq), .rga_out(register_address_bus));
    dlc_mem_model mdl (.core_clk_in(clk), .rstn_in(rstn), .slow_in(slow), .mem_req_in(mreq),
        .odd_cycle_out(odd), .mem_grant_out(grant), .mem_data_out(mdata));

    // Clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Collects fetch requests and register bus writes other than CONTROL and 0x80-0x8F
    always @(posedge clk) begin
        if (rstn === 1'b1) begin
            if (mreq.req === 1'b1) begin
                reqs++;
                last_adr = mreq.addr;
                q_adr.push_back(mreq.addr);
            end
            if (register_address_bus.strobe === 1'b1 && register_address_bus.addr != `DLC_RGA_CONTROL && register_address_bus.addr[7:4] != 4'h8) begin
                q_rga.push_back({register_address_bus.addr, register_address_bus.data});
            end
            if (register_address_bus.addr === `DLC_RGA_FETCH_IDENT) begin
                idents++;
            end
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        apb(1'b1, a, {16'h0000, d}, rd, er);
    endtask

    task automatic rdc(input string nm, input logic [11:0] a, input logic [15:0] e);
        apb(1'b0, a, 32'h00000000, rd, er);
        chk(nm, {16'h0000, e}, rd);
    endtask

    task automatic wait_q(input logic on_rga, input int n);
        int k;
        k = 0;
        while ((on_rga ? q_rga.size() : q_adr.size()) < n && k < 3000) begin
            @(posedge clk);
            k++;
        end
        chk("traffic", 32'h1, {31'h0, k < 3000});
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        {psel, pen, pwr, vbl, slow, rstn} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        beam_v = 8'h10;
        beam_h = 8'h00;
        bdone = 1'b0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rdc("control reset", `DLC_OFF_CONTROL, 16'h0000);
        wr(`DLC_OFF_CONTROL, 16'h0002);
        rdc("control set", `DLC_OFF_CONTROL, 16'h0002);
        wr(`DLC_OFF_CONTROL, 16'h0000);
        rdc("loc reset", `DLC_OFF_LOC1_HIGH, 16'h0000);
        wr(`DLC_OFF_LOC1_HIGH, 16'h0001);
        wr(`DLC_OFF_LOC1_LOW, 16'h0200);
        wr(`DLC_OFF_LOC2_HIGH, 16'h0000);
        wr(`DLC_OFF_LOC2_LOW, 16'h0400);
        rdc("loc1 high", `DLC_OFF_LOC1_HIGH, 16'h0001);
        rdc("loc1 low", `DLC_OFF_LOC1_LOW, 16'h0200);
        apb(1'b0, 12'h0FC, 32'h00000000, rd, er);
        chk("unmapped error", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        $display("test registers done");
        for (int i = 0; i < 18; i++) mdl.load(LOC_A + 18'(i), PROG_A[i]);
        for (int i = 0; i < 12; i++) mdl.load(LOC_B + 18'(i), PROG_B[i]);
        wr(`DLC_OFF_JUMP_FIRST, 16'h0000);
        wr(`DLC_OFF_RUN, 16'h0001);
        wait_q(1'b1, 1);
        repeat (60) @(posedge clk);
        reqs = 0;
        repeat (40) @(posedge clk);
        chk("requests in wait", 32'h0, reqs);
        chk("first fetch", 32'(LOC_A), 32'(q_adr[0]));
        chk("move word", {8'h00, 8'hA0, 16'hBEEF}, {8'h00, q_rga[0]});
        chk("guarded moves", 32'h1, q_rga.size());
        $display("test move and wait done");
        beam_v <= 8'h20;
        wait_q(1'b1, 3);
        repeat (100) @(posedge clk);
        reqs = 0;
        repeat (40) @(posedge clk);
        chk("requests top bit wait", 32'h0, reqs);
        chk("skip count", 32'h3, q_rga.size());
        chk("after wait", {8'h00, 8'hA2, 16'h0001}, {8'h00, q_rga[1]});
        chk("blit gated skip", {8'h00, 8'hA4, 16'h2222}, {8'h00, q_rga[2]});
        chk("own jump", 32'(LOC_B + 18'h00001), 32'(last_adr));
        $display("test skip and own jump done");
        slow <= 1'b1;
        q_rga.delete();
        beam_v <= 8'h80;
        wait_q(1'b1, 1);
        repeat (150) @(posedge clk);
        chk("danger move", {8'h00, 8'h40, 16'h4444}, {8'h00, q_rga[0]});
        rdc("control by move", `DLC_OFF_CONTROL, 16'h0002);
        chk("last fetch", 32'(LOC_B + 18'h00007), 32'(last_adr));
        beam_v <= 8'hFF;
        repeat (100) @(posedge clk);
        chk("horizontal holds", 32'(LOC_B + 18'h00007), 32'(last_adr));
        beam_h <= 8'hFE;
        repeat (100) @(posedge clk);
        chk("blit done wait", 32'(LOC_B + 18'h00009), 32'(last_adr));
        beam_h <= 8'h00;
        bdone <= 1'b1;
        repeat (100) @(posedge clk);
        chk("blit done exit", 32'(LOC_B + 18'h0000B), 32'(last_adr));
        $display("test danger and slow bus done");
        slow <= 1'b0;
        beam_v <= 8'h00;
        q_adr.delete();
        wr(`DLC_OFF_JUMP_FIRST, 16'h0000);
        wait_q(1'b0, 1);
        chk("strobe jump", 32'(LOC_A), 32'(q_adr[0]));
        repeat (100) @(posedge clk);
        q_adr.delete();
        vbl <= 1'b1;
        repeat (4) @(posedge clk);
        vbl <= 1'b0;
        wait_q(1'b0, 1);
        chk("blank reload", 32'(LOC_A), 32'(q_adr[0]));
        repeat (100) @(posedge clk);
        q_adr.delete();
        wr(`DLC_OFF_JUMP_SECOND, 16'h0000);
        wait_q(1'b0, 1);
        chk("second jump", 32'(LOC_B), 32'(q_adr[0]));
        chk("identify cycles", 32'h1, {31'h0, idents != 0});
        $display("test jumps done");
        results();
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (30000) @(posedge clk);
        mismatches++;
        results();
    end
endmodule // tb_display_list_coprocessor
`default_nettype wire
